/* File: rls_host.sv */
`include "rls_map.vh"
`timescale 1ns/10ps
`default_nettype none
module rls_host (
  // Bus pins seen from the host
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  // Lines released while idle; the clock stands still between frames
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // One bit: data moves mid low phase, sampled mid high phase
  task automatic bit_x(input logic b, output logic r);
    #20 sda_drv = b;
    #20 scl = 1'b1;
    #20 r = sda;
    #20 scl = 1'b0;
  endtask
  // Start or repeated start: data falls while the clock is high
  task automatic start();
    #20 sda_drv = 1'b1;
    #20 scl = 1'b1;
    #40 sda_drv = 1'b0;
    #40 scl = 1'b0;
  endtask
  task automatic stop();
    #20 sda_drv = 1'b0;
    #20 scl = 1'b1;
    #40 sda_drv = 1'b1;
    #40;
  endtask
  // Eight bits out or in, then the ninth (acknowledge) bit
  task automatic xbyte(input logic [7:0] d, input logic b9, output logic [7:0] q,
    output logic r9);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(b9, r9);
  endtask
  // Whole word write, low byte first; nak is set if any byte went unanswered
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] v,
    output logic nak);
    logic [7:0] q;
    logic [3:0] r;
    start();
    xbyte({a, 1'b0}, 1'b1, q, r[0]);
    xbyte(c, 1'b1, q, r[1]);
    xbyte(v[7:0], 1'b1, q, r[2]);
    xbyte(v[15:8], 1'b1, q, r[3]);
    stop();
    nak = |r;
  endtask
  // Word read: command, repeated start with no stop, both bytes, final NACK
  task automatic rd(input logic [7:0] c, output logic [15:0] v, output logic nak);
    logic [2:0] r;
    logic x;
    start();
    xbyte({`RLS_BUS_ADDR, 1'b0}, 1'b1, v[7:0], r[0]);
    xbyte(c, 1'b1, v[7:0], r[1]);
    start();
    xbyte({`RLS_BUS_ADDR, 1'b1}, 1'b1, v[7:0], r[2]);
    xbyte(8'hff, 1'b0, v[7:0], x);
    xbyte(8'hff, 1'b1, v[15:8], x);
    stop();
    nak = |r;
  endtask
endmodule // rls_host
`default_nettype wire

/* File: rls_map.vh */
// Summary of operation
// - One 16-bit control word at command code zero holds all measurement settings.
// - Bits 6..4 pick integration time, 40 ms doubling up to 1280 ms.
// - One-shot bit set in forced mode runs exactly one measurement cycle.
// - Bit 1 selects continuous automatic (0) or forced one-shot (1) mode.
// - Bit 0 set shuts the sensor down; clear keeps it enabled.
// - Control word high byte is reserved and defaults to zero.
// - Command codes 01h..07h are reserved and read zero.
// - Each of four channel results is 16 bits carried as two bytes.
// - Results red 08h, green 09h, blue 0Ah, broadband 0Bh, read only.
// - Each register transfer sends low byte first, then high byte.
// - Results hold unchanged until a new measurement completes, then overwrite.
// - Each doubling of integration time halves green lux-per-count scale.
// - Device answers seven-bit bus address 10h.
`ifndef RLS_MAP_VH
`define RLS_MAP_VH
`define RLS_BUS_ADDR 7'h10
`define RLS_CMD_CTRL 8'h00
`define RLS_CMD_RSVD_LAST 8'h07
`define RLS_CMD_RED 8'h08
`define RLS_CMD_GREEN 8'h09
`define RLS_CMD_BLUE 8'h0a
`define RLS_CMD_BROAD 8'h0b
`define RLS_CTRL_RESET 16'h0000
`define RLS_CTRL_WMASK 16'h0077
`define RLS_SHUTDOWN_BIT 0
`define RLS_FORCED_BIT 1
`define RLS_ONESHOT_BIT 2
`define RLS_IT_LSB 4
`define RLS_IT_MSB 6
`define RLS_BASE_MS 40
`define RLS_CLK_KHZ 100000
`define RLS_BASE_CYC (`RLS_BASE_MS * `RLS_CLK_KHZ)
`endif

/* File: rls_meas_timer.v */
`include "rls_map.vh"
`timescale 1ns/10ps
`default_nettype none
module rls_meas_timer #(
  parameter BASE_CYC = `RLS_BASE_CYC
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Control
  input wire run,
  input wire [2:0] it_sel,
  // Completion pulse
  output reg done_ff
);
  reg [31:0] cnt_ff;
  reg [31:0] limit;
  // Window length doubles per code step; codes above 5 saturate at 1280 ms
  always @*
  begin
    limit = BASE_CYC << ((it_sel > 3'h5) ? 3'h5 : it_sel);
  end
  // Counts while running, restarts whenever halted
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff <= 32'h0;
      done_ff <= 1'b0;
    end
    else if (!run)
    begin
      cnt_ff <= 32'h0;
      done_ff <= 1'b0;
    end
    else if (cnt_ff >= limit - 32'h1)
    begin
      cnt_ff <= 32'h0;
      done_ff <= 1'b1;
    end
    else
    begin
      cnt_ff <= cnt_ff + 32'h1;
      done_ff <= 1'b0;
    end
  end
endmodule // rls_meas_timer
`default_nettype wire

/* File: rls_props.sv */
`timescale 1ns/10ps
`default_nettype none
module rls_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Core status
  input wire logic sensor_enabled,
  input wire logic meas_active,
  input wire logic [2:0] integration_period_sel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Both lines released: bus idle, or briefly mid-transfer on a one bit or a repeated start
  sequence s_idle;
    scl_in && sda_in;
  endsequence
  sequence s_woke;
    $rose(rst_n);
  endsequence
  AST_PULL_ONLY: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  AST_OE_HOLD: assert property (scl_in [*3] |-> $stable(sda_oe))
    else $error("sda moved in high phase");
  AST_IT_IDLE: assert property (s_idle [*8] |-> $stable(integration_period_sel))
    else $error("setting moved on idle bus");
  AST_RST_QUIET: assert property (s_woke |-> !sda_oe [*3])
    else $error("sda pulled after reset");
  AST_RST_CTRL: assert property (s_woke |-> integration_period_sel == 3'h0 && sensor_enabled)
    else $error("bad control after reset");
  AST_AUTO_RUN: assert property (s_woke |-> ##[1:8] meas_active)
    else $error("auto mode idle");
  AST_SHUT_STOP: assert property (!sensor_enabled [*3] |-> !meas_active)
    else $error("running in shutdown");
  AST_SHUT_HOLD: assert property (!sensor_enabled |-> !$rose(meas_active))
    else $error("started in shutdown");
endmodule // rls_props
`default_nettype wire

/* File: rls_sensor_regs.v */
`include "rls_map.vh"
`timescale 1ns/10ps
`default_nettype none
module rls_sensor_regs #(
  parameter BASE_CYC = `RLS_BASE_CYC
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Two-wire serial bus pins
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  // Measurement core samples
  input wire [15:0] red_count,
  input wire [15:0] green_count,
  input wire [15:0] blue_count,
  input wire [15:0] broad_count,
  // Core status
  output wire sensor_enabled,
  output wire meas_active,
  output wire [2:0] integration_period_sel
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_CMD = 3'h2;
  localparam ST_WR = 3'h3;
  localparam ST_RD = 3'h4;
  localparam ST_ACK = 3'h5;
  localparam ST_RACK = 3'h6;
  localparam ST_SKIP = 3'h7;

  // Two-stage synchronisers, then one more stage for edge detection
  reg [1:0] scl_sync_ff, sda_sync_ff;
  reg scl_d_ff, sda_d_ff;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else
    begin
      scl_sync_ff <= {scl_sync_ff[0], scl_in};
      sda_sync_ff <= {sda_sync_ff[0], sda_in};
      scl_d_ff <= scl_sync_ff[1];
      sda_d_ff <= sda_sync_ff[1];
    end
  end
  wire scl = scl_sync_ff[1];
  wire sda = sda_sync_ff[1];
  wire scl_rise = scl & ~scl_d_ff;
  wire scl_fall = ~scl & scl_d_ff;
  wire start_det = scl & scl_d_ff & sda_d_ff & ~sda;
  wire stop_det = scl & scl_d_ff & ~sda_d_ff & sda;

  reg [2:0] state_ff, ret_ff;
  reg [2:0] bit_ff;
  reg [7:0] shift_ff;
  reg [7:0] cmd_ff;
  reg byte_hi_ff;
  reg full_ff;
  reg drive_ff;
  reg [15:0] ctrl_ff;
  reg [15:0] tx_word_ff;
  reg [7:0] wr_lo_ff;
  reg ctrl_wr_ff;
  reg [15:0] ctrl_wdata_ff;
  reg [15:0] result_ff [0:3];
  wire meas_done;

  // Word shown for a command code; reserved codes and gaps read zero
  reg [15:0] rd_word;
  always @*
  begin
    rd_word = 16'h0000;
    if (cmd_ff == `RLS_CMD_CTRL)
      rd_word = ctrl_ff;
    else if (cmd_ff >= `RLS_CMD_RED && cmd_ff <= `RLS_CMD_BROAD)
      rd_word = result_ff[cmd_ff[1:0]];
  end

  // Byte-level slave; ACK and data bits change only while the clock is low
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= ST_IDLE;
      ret_ff <= ST_IDLE;
      bit_ff <= 3'h0;
      shift_ff <= 8'h00;
      cmd_ff <= 8'h00;
      byte_hi_ff <= 1'b0;
      full_ff <= 1'b0;
      drive_ff <= 1'b0;
      tx_word_ff <= 16'h0000;
      wr_lo_ff <= 8'h00;
      ctrl_wr_ff <= 1'b0;
      ctrl_wdata_ff <= 16'h0000;
    end
    else
    begin
      ctrl_wr_ff <= 1'b0;
      if (start_det)
      begin
        // Repeated start keeps the command code for the read phase
        state_ff <= ST_ADDR;
        bit_ff <= 3'h0;
        full_ff <= 1'b0;
        drive_ff <= 1'b0;
        byte_hi_ff <= 1'b0;
      end
      else if (stop_det)
      begin
        state_ff <= ST_IDLE;
        drive_ff <= 1'b0;
      end
      else
      begin
        case (state_ff)
          ST_ADDR, ST_CMD, ST_WR:
          begin
            if (scl_rise)
            begin
              shift_ff <= {shift_ff[6:0], sda};
              bit_ff <= bit_ff + 3'h1;
              if (bit_ff == 3'h7)
                full_ff <= 1'b1;
            end
            // The counter alone cannot tell a full byte from the fall right after a start
            if (scl_fall && full_ff)
            begin
              // A full byte has arrived
              full_ff <= 1'b0;
              if (state_ff == ST_ADDR)
              begin
                if (shift_ff[7:1] == `RLS_BUS_ADDR)
                begin
                  drive_ff <= 1'b1;
                  ret_ff <= shift_ff[0] ? ST_RD : ST_CMD;
                  tx_word_ff <= rd_word;
                  state_ff <= ST_ACK;
                end
                else
                  state_ff <= ST_SKIP;
              end
              else if (state_ff == ST_CMD)
              begin
                cmd_ff <= shift_ff;
                drive_ff <= 1'b1;
                ret_ff <= ST_WR;
                state_ff <= ST_ACK;
              end
              else
              begin
                drive_ff <= 1'b1;
                ret_ff <= ST_WR;
                state_ff <= ST_ACK;
                if (!byte_hi_ff)
                  wr_lo_ff <= shift_ff;
                else if (cmd_ff == `RLS_CMD_CTRL)
                begin
                  ctrl_wr_ff <= 1'b1;
                  ctrl_wdata_ff <= {shift_ff, wr_lo_ff};
                end
                byte_hi_ff <= ~byte_hi_ff;
              end
            end
          end
          ST_ACK:
          begin
            // Release ACK after the ninth clock
            if (scl_fall)
            begin
              state_ff <= ret_ff;
              bit_ff <= 3'h0;
              drive_ff <= (ret_ff == ST_RD) && !tx_word_ff[7];
            end
          end
          ST_RD:
          begin
            if (scl_fall)
            begin
              bit_ff <= bit_ff + 3'h1;
              if (bit_ff == 3'h7)
              begin
                drive_ff <= 1'b0;
                state_ff <= ST_RACK;
              end
              else
                drive_ff <= !tx_word_ff[3'h6 - bit_ff];
            end
          end
          ST_RACK:
          begin
            // Host ACK moves to high byte, NACK ends the read
            if (scl_rise)
            begin
              if (sda)
                state_ff <= ST_SKIP;
              else
              begin
                tx_word_ff <= {8'h00, tx_word_ff[15:8]};
                ret_ff <= ST_RD;
              end
            end
            if (scl_fall && state_ff == ST_RACK)
            begin
              state_ff <= ST_RD;
              bit_ff <= 3'h0;
              drive_ff <= !tx_word_ff[7];
            end
          end
          ST_SKIP:
            drive_ff <= 1'b0;
          default:
            state_ff <= ST_IDLE;
        endcase
      end
    end
  end

  // Open-drain data: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = drive_ff;

  // Control word and measurement sequencing
  reg busy_ff;
  wire forced = ctrl_ff[`RLS_FORCED_BIT];
  wire shut = ctrl_ff[`RLS_SHUTDOWN_BIT];
  wire run = !shut && (!forced || ctrl_ff[`RLS_ONESHOT_BIT]);
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_ff <= `RLS_CTRL_RESET;
      busy_ff <= 1'b0;
    end
    else
    begin
      busy_ff <= run;
      if (ctrl_wr_ff)
        ctrl_ff <= ctrl_wdata_ff & `RLS_CTRL_WMASK;
      else if (meas_done && forced)
        ctrl_ff[`RLS_ONESHOT_BIT] <= 1'b0;
    end
  end

  rls_meas_timer #(
    .BASE_CYC(BASE_CYC)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .run(run),
    .it_sel(ctrl_ff[`RLS_IT_MSB:`RLS_IT_LSB]),
    .done_ff(meas_done)
  );

  // Results latch only at end of a window; held otherwise
  wire [63:0] samples = {broad_count, blue_count, green_count, red_count};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_res
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          result_ff[gi] <= 16'h0000;
        else if (meas_done)
          result_ff[gi] <= samples[gi*16 +: 16];
      end
    end
  endgenerate

  assign sensor_enabled = !shut;
  assign meas_active = busy_ff;
  assign integration_period_sel = ctrl_ff[`RLS_IT_MSB:`RLS_IT_LSB];
endmodule // rls_sensor_regs
`default_nettype wire

/* File: test_rls_sensor_regs.sv */
`include "rls_map.vh"
`timescale 1ns/10ps
`default_nettype none
module test_rls_sensor_regs;
  localparam int BASE = 100;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] cnt_v [4];
  logic [15:0] w;
  logic nak;
  int mismatches = 0;
  int checked = 0;
  wire sda_out, sda_oe, sensor_enabled, meas_active, scl, sda_drv;
  wire [2:0] integration_period_sel;
  // Open-drain line with pull-up: low whenever either side pulls
  wire sda = sda_drv & ~(sda_oe & ~sda_out);
  rls_host host_u (.scl(scl), .sda_drv(sda_drv), .sda(sda));
  rls_sensor_regs #(.BASE_CYC(BASE)) dut_u (.clk(clk), .rst_n(rst_n), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .red_count(cnt_v[0]),
    .green_count(cnt_v[1]), .blue_count(cnt_v[2]), .broad_count(cnt_v[3]),
    .sensor_enabled(sensor_enabled), .meas_active(meas_active),
    .integration_period_sel(integration_period_sel));
  // 100 MHz clock
  always #5 clk = ~clk;
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  // Control word write then read-back
  task automatic ctrl(input logic [15:0] v, input logic [15:0] e);
    host_u.wr(`RLS_BUS_ADDR, `RLS_CMD_CTRL, v, nak);
    host_u.rd(`RLS_CMD_CTRL, w, nak);
    chk("ctrl", e, w);
  endtask
  task automatic t_reset();
    host_u.rd(`RLS_CMD_CTRL, w, nak);
    chk("ctrl rst", 16'h0000, w);
    chk("ack", 16'h0000, {15'h0, nak});
    chk("enabled", 16'h0001, {15'h0, sensor_enabled});
  endtask
  // Reserved codes drop writes; reserved control bits read zero
  task automatic t_rsvd();
    for (int c = 1; c <= 7; c++)
    begin
      host_u.wr(`RLS_BUS_ADDR, 8'(c), 16'hffff, nak);
      host_u.rd(8'(c), w, nak);
      chk("rsvd", 16'h0000, w);
    end
    ctrl(16'hffff, 16'h0077);
  endtask
  // One-shot window length per code, then the request bit clears itself
  task automatic t_window();
    int hi;
    int ex;
    for (int c = 0; c <= 5; c++)
    begin
      ctrl(16'h0002, 16'h0002);
      for (int i = 0; i < 4; i++) cnt_v[i] = {4'(c), 4'(i), 4'(i), 4'hc};
      hi = 0;
      ex = BASE << c;
      fork
        host_u.wr(`RLS_BUS_ADDR, `RLS_CMD_CTRL, {9'h0, 3'(c), 4'h6}, nak);
        repeat (ex + 700) @(negedge clk) hi += meas_active;
      join
      chk("window", 16'h1, {15'h0, hi >= ex - 2 && hi <= ex + 2});
      chk("it sel", 16'(c), {13'h0, integration_period_sel});
      host_u.rd(`RLS_CMD_CTRL, w, nak);
      chk("clear", {9'h0, 3'(c), 4'h2}, w);
    end
  endtask
  // Stored results hold while idle, each channel low byte first
  task automatic t_hold();
    for (int i = 0; i < 4; i++) cnt_v[i] = 16'h0f0f;
    repeat (300) @(negedge clk);
    for (int i = 0; i < 4; i++)
    begin
      host_u.rd(`RLS_CMD_RED + 8'(i), w, nak);
      chk("result", {4'h5, 4'(i), 4'(i), 4'hc}, w);
    end
  endtask
  // Auto mode refreshes; shutdown freezes; a foreign address is ignored
  task automatic t_auto();
    ctrl(16'h0000, 16'h0000);
    repeat (3 * BASE) @(negedge clk);
    host_u.rd(`RLS_CMD_GREEN, w, nak);
    chk("auto", 16'h0f0f, w);
    ctrl(16'h0001, 16'h0001);
    chk("enabled", 16'h0000, {15'h0, sensor_enabled});
    cnt_v[1] = 16'h1234;
    repeat (3 * BASE) @(negedge clk);
    host_u.rd(`RLS_CMD_GREEN, w, nak);
    chk("frozen", 16'h0f0f, w);
    host_u.wr(7'h11, `RLS_CMD_CTRL, 16'h0050, nak);
    chk("nak", 16'h0001, {15'h0, nak});
    host_u.rd(`RLS_CMD_CTRL, w, nak);
    chk("ctrl kept", 16'h0001, w);
  endtask
  // Reset during shutdown restores the control word and wakes the sensor
  task automatic t_rerun();
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    host_u.rd(`RLS_CMD_CTRL, w, nak);
    chk("ctrl rerun", 16'h0000, w);
    chk("enabled rerun", 16'h0001, {15'h0, sensor_enabled});
  endtask
  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence: reset for four cycles, then the scenarios
  initial
  begin
    for (int i = 0; i < 4; i++) cnt_v[i] = 16'h0000;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_rsvd();
    t_window();
    t_hold();
    t_auto();
    t_rerun();
    final_report();
  end
  // Watchdog: roughly twice the expected run of about 30k cycles
  initial
  begin
    #600000;
    mismatches++;
    final_report();
  end
endmodule // test_rls_sensor_regs
bind rls_sensor_regs rls_props props_u (.clk(clk), .rst_n(rst_n), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .sensor_enabled(sensor_enabled),
  .meas_active(meas_active), .integration_period_sel(integration_period_sel));
`default_nettype wire
